// *** lsr_pkg.sv ***
package lsr_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] LSR_OFS_OVL_BILL = 8'h11;
  localparam logic [7:0] LSR_OFS_RING_MODE = 8'h12;
  localparam logic [7:0] LSR_OFS_FAULT = 8'h13;
  localparam logic [7:0] LSR_OFS_IRQ_MASK = 8'h03;
  localparam logic [7:0] LSR_OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0] LSR_OFS_AUX_CTRL = 8'h18;

  // ==========================================================================
  // Field positions
  localparam int LSR_BIT_BILL_SEEN = 0;
  localparam int LSR_BIT_RX_OVL_STICKY = 1;
  localparam int LSR_BIT_BILL_ENABLE = 2;
  localparam int LSR_BIT_RING_RESV = 2;
  localparam int LSR_BIT_RING_FULLWAVE = 1;
  localparam int LSR_BIT_OVERCURRENT = 0;
  localparam int LSR_BIT_DROPOUT = 1;
  localparam int LSR_BIT_RX_OVL_LIVE = 2;
  localparam int LSR_BIT_IRQ_BILL = 0;
  localparam int LSR_BIT_IRQ_DROPOUT = 2;
  localparam int LSR_BIT_IRQ_OVERCURRENT = 3;
  localparam int LSR_BIT_IRQ_RX_OVL = 6;
  localparam int LSR_BIT_AUX_RING_VALID = 0;
  localparam int LSR_BIT_AUX_CURRENT_LIMIT_SELECT = 1;

  // Writable storage in the overload/billing register, bits 7:2
  localparam logic [7:0] LSR_OVL_BILL_RW_MASK = 8'hfc;
  localparam logic [7:0] LSR_IRQ_USED_MASK = 8'h4d;
  localparam logic [7:0] LSR_AUX_USED_MASK = 8'h03;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] LSR_RST_OVL_BILL = 8'h00;
  localparam logic [7:0] LSR_RST_RING_MODE = 8'h00;
  localparam logic [7:0] LSR_RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] LSR_RST_IRQ_STATUS = 8'h00;
  localparam logic [7:0] LSR_RST_AUX_CTRL = 8'h00;

  // ==========================================================================
  // Overcurrent thresholds and one-shot timing
  localparam logic [7:0] LSR_OVERCURRENT_MA_NORMAL = 8'd160;
  localparam logic [7:0] LSR_OVERCURRENT_MA_LIMITED = 8'd60;
  localparam longint LSR_CLK_HZ = 125000000;
  localparam longint LSR_ONESHOT_S = 5;
  localparam longint LSR_ONESHOT_CYCLES = LSR_ONESHOT_S * LSR_CLK_HZ;
  localparam int LSR_ONESHOT_W = 30;

  // ==========================================================================
  // Line-side event inputs, all asynchronous levels
  typedef struct packed {
    logic rx_below_ground;
    logic billing_event;
    logic ring_threshold;
    logic ring_envelope;
    logic ring_halfwave;
    logic ring_fullwave;
    logic offhook_settling;
    logic loop_current_flowing;
    logic offhook;
    logic line_side_enabled;
  } lsr_line_events_t;

  typedef enum logic [1:0] {
    LSR_OS_IDLE = 2'b01,
    LSR_OS_RUN = 2'b10
  } lsr_os_state_t;

endpackage

// *** lsr_line_status_regs.sv ***
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module lsr_line_status_regs #(
  parameter longint ONESHOT_CYCLES = lsr_pkg::LSR_ONESHOT_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire lsr_pkg::lsr_line_events_t events_i,
  input wire logic [7:0] loop_current_ma_i,
  output logic ring_detect_pin_o,
  output logic irq_o
);
  import lsr_pkg::*;

  // ==========================================================================
  // Reset release
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // Input synchronisers
  lsr_line_events_t ev_meta_reg;
  lsr_line_events_t ev_sync_reg;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ev_meta_reg <= '0;
      ev_sync_reg <= '0;
    end else begin
      ev_meta_reg <= events_i;
      ev_sync_reg <= ev_meta_reg;
    end
  end

  // Previous sample for edge detection, taken from the second stage only
  lsr_line_events_t ev_prev_reg;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ev_prev_reg <= '0;
    end else begin
      ev_prev_reg <= ev_sync_reg;
    end
  end

  // ==========================================================================
  // Address decode
  wire sel_ovl_bill = (addr_i == LSR_OFS_OVL_BILL);
  wire sel_ring_mode = (addr_i == LSR_OFS_RING_MODE);
  wire sel_fault = (addr_i == LSR_OFS_FAULT);
  wire sel_irq_mask = (addr_i == LSR_OFS_IRQ_MASK);
  wire sel_irq_status = (addr_i == LSR_OFS_IRQ_STATUS);
  wire sel_aux = (addr_i == LSR_OFS_AUX_CTRL);

  wire wr_ovl_bill = wr_i && sel_ovl_bill;
  wire wr_ring_mode = wr_i && sel_ring_mode;
  wire wr_irq_mask = wr_i && sel_irq_mask;
  wire wr_aux = wr_i && sel_aux;
  wire rd_irq_status = rd_i && sel_irq_status;

  // ==========================================================================
  // Control storage
  logic [7:0] ctrl_reg;
  logic [7:0] ring_mode_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] aux_reg;

  wire billing_tone_enable = ctrl_reg[LSR_BIT_BILL_ENABLE];
  wire ring_fullwave_enable = ring_mode_reg[LSR_BIT_RING_FULLWAVE];
  wire ring_validation_enable = aux_reg[LSR_BIT_AUX_RING_VALID];
  wire current_limit_select = aux_reg[LSR_BIT_AUX_CURRENT_LIMIT_SELECT];

  // Only bits 2:1 are stored; everything else reads zero
  wire [7:0] ring_mode_next = {5'h00,
                               wdata_i[LSR_BIT_RING_RESV],
                               wdata_i[LSR_BIT_RING_FULLWAVE],
                               1'b0};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= LSR_RST_OVL_BILL;
      ring_mode_reg <= LSR_RST_RING_MODE;
      irq_mask_reg <= LSR_RST_IRQ_MASK;
      aux_reg <= LSR_RST_AUX_CTRL;
    end else begin
      if (wr_ovl_bill) begin
        ctrl_reg <= wdata_i & LSR_OVL_BILL_RW_MASK;
      end
      if (wr_ring_mode) begin
        ring_mode_reg <= ring_mode_next;
      end
      if (wr_irq_mask) begin
        irq_mask_reg <= wdata_i & LSR_IRQ_USED_MASK;
      end
      if (wr_aux) begin
        aux_reg <= wdata_i & LSR_AUX_USED_MASK;
      end
    end
  end

  // ==========================================================================
  // Receive overload and billing tone flags
  logic rx_overload_sticky;
  logic rx_overload_sticky_next;
  logic billing_tone_seen;
  logic billing_tone_seen_next;

  wire rx_ovl_now = ev_sync_reg.rx_below_ground;
  // Only a written zero at this position clears; a one is a no-op
  wire rx_ovl_clear = wr_ovl_bill && !wdata_i[LSR_BIT_RX_OVL_STICKY];
  // Clearing the enable is the only way to drop the billing flag
  wire bill_clear = wr_ovl_bill && !wdata_i[LSR_BIT_BILL_ENABLE];
  // Detection is not functional while disabled
  wire bill_set = ev_sync_reg.billing_event && billing_tone_enable;

  // Set beats clear so an overload during the clear write is kept
  assign rx_overload_sticky_next = rx_ovl_now ||
                                   (rx_overload_sticky && !rx_ovl_clear);
  assign billing_tone_seen_next = bill_set ||
                                  (billing_tone_seen && !bill_clear);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_overload_sticky <= 1'b0;
      billing_tone_seen <= 1'b0;
    end else begin
      rx_overload_sticky <= rx_overload_sticky_next;
      billing_tone_seen <= billing_tone_seen_next;
    end
  end

  // ==========================================================================
  // Live fault status
  logic rx_overload_live;
  logic supply_dropout_flag;
  logic loop_overcurrent_flag;

  // Settling counter is the only mask; billing enable plays no part
  wire rx_ovl_live_next = rx_ovl_now && !ev_sync_reg.offhook_settling;
  wire dropout_next = !ev_sync_reg.loop_current_flowing ||
                      (!ev_sync_reg.offhook &&
                       ev_sync_reg.line_side_enabled);
  wire [7:0] oc_threshold = current_limit_select ? LSR_OVERCURRENT_MA_LIMITED :
                                                   LSR_OVERCURRENT_MA_NORMAL;
  // Current value comes from on-chip sensing logic on this clock
  wire overcurrent_next = (loop_current_ma_i >= oc_threshold);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_overload_live <= 1'b0;
      supply_dropout_flag <= 1'b0;
      loop_overcurrent_flag <= 1'b0;
    end else begin
      rx_overload_live <= rx_ovl_live_next;
      supply_dropout_flag <= dropout_next;
      loop_overcurrent_flag <= overcurrent_next;
    end
  end

  // ==========================================================================
  // Interrupt status
  logic [7:0] irq_status_reg;
  logic [7:0] irq_status_next;
  logic dropout_prev_reg;
  logic overcurrent_prev_reg;

  // Named interrupt events
  // Billing raises the interrupt once, on the flag's first set
  wire bill_first = bill_set && !billing_tone_seen;
  // Dropout and overcurrent interrupt on their rising edge only
  wire dropout_rise = supply_dropout_flag && !dropout_prev_reg;
  wire overcurrent_rise = loop_overcurrent_flag && !overcurrent_prev_reg;
  // Mirror of the sticky overload flag
  wire rx_ovl_irq_set = rx_ovl_now;

  wire [7:0] irq_set_vec;
  assign irq_set_vec[LSR_BIT_IRQ_BILL] = bill_first;
  assign irq_set_vec[1] = 1'b0;
  assign irq_set_vec[LSR_BIT_IRQ_DROPOUT] = dropout_rise;
  assign irq_set_vec[LSR_BIT_IRQ_OVERCURRENT] = overcurrent_rise;
  assign irq_set_vec[5:4] = 2'b00;
  assign irq_set_vec[LSR_BIT_IRQ_RX_OVL] = rx_ovl_irq_set;
  assign irq_set_vec[7] = 1'b0;

  // Mirror bit also drops on the sticky flag's zero write
  wire [7:0] irq_clr_vec;
  assign irq_clr_vec = rd_irq_status ? 8'hff :
                       (rx_ovl_clear ? 8'h40 : 8'h00);

  // ==========================================================================
  // Per-bit sticky status
  // Set wins over the read clear, so an event in the read cycle is not lost
  for (genvar b = 0; b < 8; b++) begin : g_irq_bit
    assign irq_status_next[b] = irq_set_vec[b] ||
                                (irq_status_reg[b] && !irq_clr_vec[b]);

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        irq_status_reg[b] <= LSR_RST_IRQ_STATUS[b];
      end else begin
        irq_status_reg[b] <= irq_status_next[b];
      end
    end
  end

  // Previous live fault values for the rising-edge events
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dropout_prev_reg <= 1'b0;
      overcurrent_prev_reg <= 1'b0;
    end else begin
      dropout_prev_reg <= supply_dropout_flag;
      overcurrent_prev_reg <= loop_overcurrent_flag;
    end
  end

  logic irq_reg;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_next & irq_mask_reg);
    end
  end

  assign irq_o = irq_reg;

  // ==========================================================================
  // Ring threshold one-shot
  lsr_os_state_t os_state_reg;
  lsr_os_state_t os_state_next;
  logic [LSR_ONESHOT_W-1:0] os_count_reg;
  logic [LSR_ONESHOT_W-1:0] os_count_next;

  localparam logic [LSR_ONESHOT_W-1:0] OS_LAST = ONESHOT_CYCLES[LSR_ONESHOT_W-1:0] - 1'b1;
  wire ring_cross = ev_sync_reg.ring_threshold && !ev_prev_reg.ring_threshold;
  wire os_done = (os_count_reg == OS_LAST);

  // Crossings inside a running pulse do not retrigger it
  always_comb begin
    os_state_next = os_state_reg;
    os_count_next = os_count_reg;
    case (os_state_reg)
      LSR_OS_IDLE: begin
        os_count_next = '0;
        if (ring_cross) begin
          os_state_next = LSR_OS_RUN;
        end
      end
      LSR_OS_RUN: begin
        if (os_done) begin
          os_state_next = LSR_OS_IDLE;
          os_count_next = '0;
        end else begin
          os_count_next = os_count_reg + 1'b1;
        end
      end
      default: begin
        os_state_next = LSR_OS_IDLE;
        os_count_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      os_state_reg <= LSR_OS_IDLE;
      os_count_reg <= '0;
    end else begin
      os_state_reg <= os_state_next;
      os_count_reg <= os_count_next;
    end
  end

  wire os_active = (os_state_reg == LSR_OS_RUN);

  // ==========================================================================
  // Ring detect pin selection
  wire ring_raw = ring_fullwave_enable ? ev_sync_reg.ring_fullwave :
                                         ev_sync_reg.ring_halfwave;
  wire ring_validated = ring_fullwave_enable ? os_active :
                                               ev_sync_reg.ring_envelope;
  wire ring_pin_next = ring_validation_enable ? ring_validated : ring_raw;

  logic ring_pin_reg;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ring_pin_reg <= 1'b0;
    end else begin
      ring_pin_reg <= ring_pin_next;
    end
  end

  assign ring_detect_pin_o = ring_pin_reg;

  // ==========================================================================
  // Read path
  wire [7:0] ovl_bill_view = ctrl_reg |
                             {6'h00, rx_overload_sticky, billing_tone_seen};
  wire [7:0] fault_view = {5'h00, rx_overload_live,
                           supply_dropout_flag, loop_overcurrent_flag};

  wire [7:0] rd_mux = sel_ovl_bill ? ovl_bill_view :
                      sel_ring_mode ? ring_mode_reg :
                      sel_fault ? fault_view :
                      sel_irq_mask ? irq_mask_reg :
                      sel_irq_status ? irq_status_reg :
                      sel_aux ? aux_reg : 8'h00;

  logic [7:0] rdata_reg;

  // Data stands for exactly one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rd_i ? rd_mux : 8'h00;
    end
  end

  assign rdata_o = rdata_reg;

  // Fault register has no write decode at all, so writes cannot reach it

endmodule

// *** lsr_line_status_regs_monitor.sv ***
`timescale 1ns/1ps
module lsr_line_status_regs_monitor
  import lsr_pkg::*;
#(
  parameter longint ONESHOT_CYCLES = LSR_ONESHOT_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire lsr_pkg::lsr_line_events_t events_i,
  input wire logic [7:0] loop_current_ma_i,
  input wire logic ring_detect_pin_o,
  input wire logic irq_o
);
  // ========
  // Control bits shadowed from bus writes
  logic fw_reg;
  logic rv_reg;
  logic current_limit_select_reg;
  logic [7:0] msk_reg;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fw_reg <= 1'b0;
      rv_reg <= 1'b0;
      current_limit_select_reg <= 1'b0;
      msk_reg <= 8'h00;
    end else if (wr_i) begin
      if (addr_i == LSR_OFS_RING_MODE) fw_reg <= wdata_i[1];
      if (addr_i == LSR_OFS_AUX_CTRL) rv_reg <= wdata_i[0];
      if (addr_i == LSR_OFS_AUX_CTRL) current_limit_select_reg <= wdata_i[1];
      if (addr_i == LSR_OFS_IRQ_MASK) msk_reg <= wdata_i;
    end
  end
  wire ring_exp = rv_reg ? events_i.ring_envelope
    : (fw_reg ? events_i.ring_fullwave : events_i.ring_halfwave);
  wire [7:0] thr = current_limit_select_reg ? LSR_OVERCURRENT_MA_LIMITED : LSR_OVERCURRENT_MA_NORMAL;
  wire oc_exp = loop_current_ma_i >= thr;
  wire live_exp = events_i.rx_below_ground && !events_i.offhook_settling;
  wire drop_exp = !events_i.loop_current_flowing
    || (!events_i.offhook && events_i.line_side_enabled);
  wire rd_fault = rd_i && addr_i == LSR_OFS_FAULT;
  wire rd_ring = rd_i && addr_i == LSR_OFS_RING_MODE;
  wire rd_ovl = rd_i && addr_i == LSR_OFS_OVL_BILL;
  wire wr_ovl0 = wr_i && addr_i == LSR_OFS_OVL_BILL && !wdata_i[LSR_BIT_RX_OVL_STICKY];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ========
  // Long settling windows cover the two-flop input sync
  sequence lines_steady;
    $stable(events_i)[*8];
  endsequence
  sequence rx_quiet;
    (!events_i.rx_below_ground)[*4];
  endsequence
  sequence cur_steady;
    ($stable(loop_current_ma_i) && $stable(current_limit_select_reg))[*4];
  endsequence
  sequence ring_steady;
    (!(rv_reg && fw_reg) && $stable(ring_exp) && $stable({rv_reg, fw_reg}))[*6];
  endsequence
  ring_resv_a: assert property (rd_ring |=> rdata_o[7:3] == 5'h00 && !rdata_o[0])
    else $error("ring mode reserved bits not zero");
  fault_resv_a: assert property (rd_fault |=> rdata_o[7:3] == 5'h00)
    else $error("fault status upper bits not zero");
  sticky_set_a: assert property (
    lines_steady ##0 (events_i.rx_below_ground && rd_ovl) |=> rdata_o[1])
    else $error("sticky overload not set");
  irq_clear_a: assert property (
    rx_quiet ##0 (wr_ovl0 && msk_reg == 8'h40) |-> ##[1:2] !irq_o)
    else $error("overload interrupt not cleared by write");
  live_ovl_a: assert property (
    lines_steady ##0 rd_fault |=> rdata_o[2] == $past(live_exp))
    else $error("live overload bit wrong");
  dropout_bit_a: assert property (
    lines_steady ##0 rd_fault |=> rdata_o[1] == $past(drop_exp))
    else $error("dropout bit wrong");
  overcurrent_a: assert property (
    cur_steady ##0 rd_fault |=> rdata_o[0] == $past(oc_exp))
    else $error("overcurrent bit wrong");
  ring_select_a: assert property (
    ring_steady |-> ring_detect_pin_o == ring_exp)
    else $error("ring pin source wrong");
endmodule

bind lsr_line_status_regs lsr_line_status_regs_monitor #(
  .ONESHOT_CYCLES(ONESHOT_CYCLES)
) u_mon (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .events_i(events_i),
  .loop_current_ma_i(loop_current_ma_i), .ring_detect_pin_o(ring_detect_pin_o),
  .irq_o(irq_o)
);

// *** lsr_line_status_regs_test.sv ***
`timescale 1ns/1ps
module lsr_line_status_regs_test;
  import lsr_pkg::*;
  localparam longint OS_CYC = 20;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] cur = 8'h00;
  lsr_line_events_t ev = '0;
  wire [7:0] rdata_o;
  wire pin;
  wire irq;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  integer seed = 70030;
  logic rd_seen = 1'b0;
  logic [7:0] v;
  logic [7:0] exp_q[$];
  string name_q[$];
  logic [7:0] ofs[6] = '{8'h11, 8'h12, 8'h13, 8'h03, 8'h04, 8'h18};
  logic [7:0] tab[4] = '{8'd59, 8'd60, 8'd159, 8'd160};
  lsr_line_status_regs #(.ONESHOT_CYCLES(OS_CYC)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .events_i(ev),
    .loop_current_ma_i(cur), .ring_detect_pin_o(pin), .irq_o(irq)
  );
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // ========
  // Shared checks and bus cycles
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Empty name: read is issued but its result is not judged
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    exp_q.push_back(e);
    name_q.push_back(n);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic see(input bit p, input logic e);
    #1;
    check(p ? "ring pin" : "irq", {7'h00, p ? pin : irq}, {7'h00, e});
  endtask
  always @(posedge clk_i) begin
    rd_seen <= rd_i;
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  always @(negedge clk_i) begin
    string n;
    logic [7:0] e;
    if (rd_seen) begin
      n = name_q.pop_front();
      e = exp_q.pop_front();
      if (n != "") check(n, rdata_o, e);
    end
  end
  // ========
  // Main sequence
  initial begin
    ev.loop_current_flowing = 1'b1;
    ev.offhook = 1'b1;
    idle(6);
    reset_n_i <= 1'b1;
    idle(12);
    rd(LSR_OFS_IRQ_STATUS, 8'h00, "");
    foreach (ofs[i]) rd(ofs[i], 8'h00, "reset value");
    rd(8'h55, 8'h00, "unmapped");
    $display("test reset done");
    repeat (4) begin
      v = 8'($random(seed));
      wr(LSR_OFS_RING_MODE, v);
      rd(LSR_OFS_RING_MODE, v & 8'h06, "ring mode");
      wr(LSR_OFS_FAULT, v);
      rd(LSR_OFS_FAULT, 8'h00, "fault ro");
      wr(LSR_OFS_OVL_BILL, (v & 8'hfb) | 8'h02);
      rd(LSR_OFS_OVL_BILL, v & 8'hf8, "ovl bill");
      wr(LSR_OFS_AUX_CTRL, v);
      rd(LSR_OFS_AUX_CTRL, v & 8'h03, "aux");
    end
    wr(LSR_OFS_RING_MODE, 8'h00);
    wr(LSR_OFS_OVL_BILL, 8'h00);
    wr(LSR_OFS_AUX_CTRL, 8'h00);
    $display("test registers done");
    wr(LSR_OFS_IRQ_MASK, 8'h40);
    ev.rx_below_ground <= 1'b1;
    idle(10);
    rd(LSR_OFS_FAULT, 8'h04, "live on");
    rd(LSR_OFS_OVL_BILL, 8'h02, "sticky on");
    see(0, 1'b1);
    ev.offhook_settling <= 1'b1;
    idle(8);
    rd(LSR_OFS_FAULT, 8'h00, "live masked");
    ev.offhook_settling <= 1'b0;
    ev.rx_below_ground <= 1'b0;
    idle(8);
    rd(LSR_OFS_FAULT, 8'h00, "live cleared");
    wr(LSR_OFS_OVL_BILL, 8'h02);
    rd(LSR_OFS_OVL_BILL, 8'h02, "sticky kept");
    see(0, 1'b1);
    wr(LSR_OFS_OVL_BILL, 8'h00);
    idle(2);
    see(0, 1'b0);
    rd(LSR_OFS_OVL_BILL, 8'h00, "sticky cleared");
    rd(LSR_OFS_IRQ_STATUS, 8'h00, "irq mirror cleared");
    wr(LSR_OFS_IRQ_MASK, 8'h00);
    ev.rx_below_ground <= 1'b1;
    idle(5);
    ev.rx_below_ground <= 1'b0;
    idle(6);
    see(0, 1'b0);
    wr(LSR_OFS_IRQ_MASK, 8'h40);
    idle(2);
    see(0, 1'b1);
    rd(LSR_OFS_IRQ_STATUS, 8'h40, "irq status");
    rd(LSR_OFS_IRQ_STATUS, 8'h00, "irq read clear");
    wr(LSR_OFS_OVL_BILL, 8'h00);
    wr(LSR_OFS_IRQ_MASK, 8'h00);
    $display("test overload done");
    wr(LSR_OFS_OVL_BILL, 8'h04);
    ev.billing_event <= 1'b1;
    idle(6);
    ev.billing_event <= 1'b0;
    idle(4);
    rd(LSR_OFS_OVL_BILL, 8'h05, "billing set");
    wr(LSR_OFS_OVL_BILL, 8'h06);
    rd(LSR_OFS_OVL_BILL, 8'h05, "billing kept");
    rd(LSR_OFS_IRQ_STATUS, 8'h01, "billing irq");
    wr(LSR_OFS_OVL_BILL, 8'h00);
    rd(LSR_OFS_OVL_BILL, 8'h00, "billing cleared");
    $display("test billing done");
    for (int i = 0; i < 8; i++) begin
      {ev.loop_current_flowing, ev.offhook, ev.line_side_enabled} <= i[2:0];
      idle(10);
      rd(LSR_OFS_FAULT, {6'h00, !i[2] || (!i[1] && i[0]), 1'b0}, "dropout");
    end
    {ev.loop_current_flowing, ev.offhook, ev.line_side_enabled} <= 3'b110;
    for (int k = 0; k < 10; k++) begin
      wr(LSR_OFS_AUX_CTRL, {6'h00, k > 4, 1'b0});
      v = (k % 5 == 4) ? 8'($random(seed)) : tab[k % 5];
      cur <= v;
      idle(5);
      rd(LSR_OFS_FAULT, {7'h00, v >= (k > 4 ? 8'd60 : 8'd160)}, "overcurrent");
    end
    $display("test fault status done");
    for (int m = 0; m < 3; m++) begin
      wr(LSR_OFS_AUX_CTRL, {7'h00, m == 2});
      wr(LSR_OFS_RING_MODE, {6'h00, m == 1, 1'b0});
      repeat (4) begin
        v = 8'($random(seed));
        ev.ring_halfwave <= v[0];
        ev.ring_fullwave <= v[1];
        ev.ring_envelope <= v[2];
        idle(7);
        see(1, m == 0 ? v[0] : (m == 1 ? v[1] : v[2]));
      end
    end
    wr(LSR_OFS_AUX_CTRL, 8'h01);
    wr(LSR_OFS_RING_MODE, 8'h06);
    idle(4);
    see(1, 1'b0);
    ev.ring_threshold <= 1'b1;
    idle(6);
    see(1, 1'b1);
    idle(10);
    see(1, 1'b1);
    idle(OS_CYC - 8);
    see(1, 1'b0);
    ev.ring_threshold <= 1'b0;
    $display("test ring pin done");
    idle(4);
    complete_run();
  end
endmodule
